// *** verilog/log_sense_pkg.sv ***
// Operation
// - Opcode 4Dh requests stored logs and state
// - Initiator keeps pointer-control bit clear
// - Parameters ascending from pointer, capped by allocation
// - Zero pointer returns every parameter of page
// - Save bit clear; nothing is ever saved
// - Page control must be 01b, cumulative only
// - Unsupported page code gives illegal request
// - Pages 00h, 30h, 31h, 32h are accepted
// - Pointer picks first parameter; stop at smaller limit
// - Pointer above largest code gives illegal request
// - Page zero needs pointer zero from initiator
// - Negative pointer is tolerated, not rejected
// - Allocation length caps; end when page exhausted
// - Page starts with four-byte header and length
// - Status, then completion message, then bus free
package log_sense_pkg;
    // ------------------------------------------------------------
    // Descriptor block
    // ------------------------------------------------------------
    localparam logic [7:0] OPCODE_LOG_SENSE = 8'h4D;
    localparam logic [3:0] CDB_LEN = 4'hA;
    localparam int PPC_BIT = 1;
    localparam int SP_BIT = 0;
    localparam logic [1:0] PAGE_CTRL_CUMULATIVE = 2'h1;
    // ------------------------------------------------------------
    // Pages and parameters
    // ------------------------------------------------------------
    localparam logic [5:0] PAGE_SUPPORTED = 6'h00;
    localparam logic [5:0] PAGE_STATISTICS = 6'h30;
    localparam logic [5:0] PAGE_STATE = 6'h31;
    localparam logic [5:0] PAGE_HISTORY = 6'h32;
    localparam logic [15:0] PAGE_HDR_BYTES = 16'h0004;
    localparam logic [15:0] SUPPORTED_PAGE_BYTES = 16'h0008;
    localparam logic [15:0] PARAM_COUNT = 16'h0004;
    localparam logic [7:0] PARAM_VALUE_LEN = 8'h02;
    localparam logic [15:0] PARAM_BYTES = 16'h0006;
    localparam int VALUE_BITS = 16;
    localparam int LOG_VALUES_BITS = 3 * 4 * VALUE_BITS;
    // ------------------------------------------------------------
    // Status, sense and message bytes
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_GOOD = 8'h00;
    localparam logic [7:0] STATUS_CHECK = 8'h02;
    localparam logic [7:0] MSG_COMMAND_COMPLETE = 8'h00;
    localparam logic [3:0] SENSE_NONE = 4'h0;
    localparam logic [3:0] SENSE_ILLEGAL_REQUEST = 4'h5;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_INVALID_OPCODE = 8'h20;
    localparam logic [7:0] ASC_INVALID_FIELD_CDB = 8'h24;
    // ------------------------------------------------------------
    // Link phases and buffering
    // ------------------------------------------------------------
    localparam logic [1:0] PHASE_DATA_IN = 2'h0;
    localparam logic [1:0] PHASE_STATUS = 2'h1;
    localparam logic [1:0] PHASE_MSG_IN = 2'h2;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
endpackage : log_sense_pkg

// *** verilog/scsi_link_if.sv ***
`timescale 1ns/1ps
interface scsi_link_if;
    // Descriptor bytes, initiator to target
    logic cdb_valid;
    logic [7:0] cdb_data;
    logic cdb_ready;
    // Data-in, status and message bytes, target to initiator
    logic tgt_valid;
    logic [7:0] tgt_data;
    logic [1:0] tgt_phase;
    logic ini_ready;
    // Target holds the bus from first descriptor byte to bus free
    logic bus_busy;
    modport target (input cdb_valid, input cdb_data, output cdb_ready,
                    output tgt_valid, output tgt_data, output tgt_phase,
                    input ini_ready, output bus_busy);
    modport initiator (output cdb_valid, output cdb_data, input cdb_ready,
                       input tgt_valid, input tgt_data, input tgt_phase,
                       output ini_ready, input bus_busy);
endinterface : scsi_link_if

// *** verilog/log_sense_target.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Byte FIFO between page generator and data-in phase
// ----------------------------------------------------------------
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push = in_valid_in && !full;
    wire pop = out_ready_in && !empty;

    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : byte_fifo

// ----------------------------------------------------------------
// Target end: descriptor check and log page streaming
// ----------------------------------------------------------------
module log_sense_target (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link to initiator
    scsi_link_if.target link,
    // Page 30h..32h values, four per page, 16 bits
    input wire logic [log_sense_pkg::LOG_VALUES_BITS-1:0] log_values_in,
    // Sense of last command
    output logic [3:0] sense_key_out,
    output logic [7:0] asc_out,
    output logic busy_out
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_CHECK = 6'b000010,
        S_DATA = 6'b000100,
        S_STATUS = 6'b001000,
        S_MSG = 6'b010000,
        S_UNUSED = 6'b100000
    } state_type;

    state_type state, next_state;
    logic [7:0] cdb [10];
    logic [3:0] cdb_idx;
    logic [15:0] gen_idx, gen_limit;
    logic [7:0] status_byte;
    logic fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_out_data;

    // ------------------------------------------------------------
    // Page byte generator
    // ------------------------------------------------------------
    function automatic logic [7:0] page_byte(input logic [5:0] page, input logic [15:0] start,
                                             input logic [15:0] idx, input logic [15:0] plen,
                                             input logic [log_sense_pkg::LOG_VALUES_BITS-1:0] vals);
        logic [15:0] k, code, v;
        logic [2:0] off;
        logic [7:0] b;
        k = idx - log_sense_pkg::PAGE_HDR_BYTES;
        code = start + (k / log_sense_pkg::PARAM_BYTES);
        off = 3'(k % log_sense_pkg::PARAM_BYTES);
        v = vals[{page[1:0] - 2'h0, code[1:0]} * log_sense_pkg::VALUE_BITS +: log_sense_pkg::VALUE_BITS];
        if (idx == 16'h0000) begin
            b = {2'h0, page};
        end else if (idx == 16'h0001) begin
            b = 8'h00;
        end else if (idx == 16'h0002) begin
            b = plen[15:8];
        end else if (idx == 16'h0003) begin
            b = plen[7:0];
        end else if (page == log_sense_pkg::PAGE_SUPPORTED) begin
            case (idx[1:0])
                2'h0: b = {2'h0, log_sense_pkg::PAGE_SUPPORTED};
                2'h1: b = {2'h0, log_sense_pkg::PAGE_STATISTICS};
                2'h2: b = {2'h0, log_sense_pkg::PAGE_STATE};
                default: b = {2'h0, log_sense_pkg::PAGE_HISTORY};
            endcase
        end else begin
            // Parameters ascend from the pointer
            case (off)
                3'h0: b = code[15:8];
                3'h1: b = code[7:0];
                3'h2: b = 8'h00;
                3'h3: b = log_sense_pkg::PARAM_VALUE_LEN;
                3'h4: b = v[15:8];
                default: b = v[7:0];
            endcase
        end
        return b;
    endfunction : page_byte

    // ------------------------------------------------------------
    // Descriptor decode
    // ------------------------------------------------------------
    wire [5:0] page = cdb[2][5:0];
    wire [15:0] pointer = {cdb[5], cdb[6]};
    wire [15:0] alloc_len = {cdb[7], cdb[8]};
    wire bad_opcode = cdb[0] != log_sense_pkg::OPCODE_LOG_SENSE;
    wire bad_ctrl = cdb[1][log_sense_pkg::PPC_BIT] || cdb[1][log_sense_pkg::SP_BIT]
        || (cdb[2][7:6] != log_sense_pkg::PAGE_CTRL_CUMULATIVE);
    wire bad_reserved = (cdb[1][4:2] != 3'h0) || (cdb[3] != 8'h00) || (cdb[4] != 8'h00);
    wire page_ok = (page == log_sense_pkg::PAGE_SUPPORTED) || (page == log_sense_pkg::PAGE_STATISTICS)
        || (page == log_sense_pkg::PAGE_STATE) || (page == log_sense_pkg::PAGE_HISTORY);
    // Negative pointer starts at code zero
    wire ptr_negative = pointer[15];
    wire [15:0] start_code = ptr_negative ? 16'h0000 : pointer;
    wire [15:0] max_code = (page == log_sense_pkg::PAGE_SUPPORTED) ? 16'h0000 : log_sense_pkg::PARAM_COUNT - 16'h0001;
    wire ptr_bad = !ptr_negative && (pointer > max_code);
    wire bad_field = bad_ctrl || bad_reserved || !page_ok || ptr_bad;
    // Zero pointer covers the whole page
    wire [15:0] param_len = 16'((log_sense_pkg::PARAM_COUNT - start_code) * log_sense_pkg::PARAM_BYTES);
    wire [15:0] page_total = (page == log_sense_pkg::PAGE_SUPPORTED) ? log_sense_pkg::SUPPORTED_PAGE_BYTES
        : log_sense_pkg::PAGE_HDR_BYTES + param_len;
    wire [15:0] page_len_field = page_total - log_sense_pkg::PAGE_HDR_BYTES;
    wire [15:0] limit = (alloc_len < page_total) ? alloc_len : page_total;
    wire gen_more = gen_idx < gen_limit;
    wire fifo_in_valid = (state == S_DATA) && gen_more;
    wire [7:0] gen_byte = page_byte(page, start_code, gen_idx, page_len_field, log_values_in);
    wire cdb_take = link.cdb_valid && (state == S_IDLE);

    // ------------------------------------------------------------
    // Link outputs
    // ------------------------------------------------------------
    assign link.cdb_ready = (state == S_IDLE);
    assign link.tgt_valid = ((state == S_DATA) && fifo_out_valid) || (state == S_STATUS) || (state == S_MSG);
    assign link.tgt_phase = (state == S_STATUS) ? log_sense_pkg::PHASE_STATUS
        : (state == S_MSG) ? log_sense_pkg::PHASE_MSG_IN : log_sense_pkg::PHASE_DATA_IN;
    assign link.tgt_data = (state == S_DATA) ? fifo_out_data
        : (state == S_STATUS) ? status_byte : log_sense_pkg::MSG_COMMAND_COMPLETE;
    assign link.bus_busy = (state != S_IDLE) || (cdb_idx != 4'h0);
    assign busy_out = link.bus_busy;

    byte_fifo #(
        .WIDTH(log_sense_pkg::FIFO_WIDTH),
        .DEPTH(log_sense_pkg::FIFO_DEPTH)
    ) data_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(fifo_in_valid),
        .in_data_in(gen_byte),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(link.ini_ready && (state == S_DATA))
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (cdb_take && (cdb_idx == log_sense_pkg::CDB_LEN - 4'h1)) begin
                    next_state = S_CHECK;
                end
            end
            S_CHECK: begin
                next_state = (bad_opcode || bad_field || (limit == 16'h0000)) ? S_STATUS : S_DATA;
            end
            S_DATA: begin
                // Ends once the capped count has drained
                if (!gen_more && !fifo_out_valid) begin
                    next_state = S_STATUS;
                end
            end
            S_STATUS: begin
                if (link.ini_ready) begin
                    next_state = S_MSG;
                end
            end
            S_MSG: begin
                if (link.ini_ready) begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= S_IDLE;
            cdb_idx <= 4'h0;
        end else begin
            state <= next_state;
            if (cdb_take) begin
                cdb[cdb_idx] <= link.cdb_data;
                cdb_idx <= (cdb_idx == log_sense_pkg::CDB_LEN - 4'h1) ? 4'h0 : cdb_idx + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gen_idx <= 16'h0000;
            gen_limit <= 16'h0000;
            status_byte <= log_sense_pkg::STATUS_GOOD;
            sense_key_out <= log_sense_pkg::SENSE_NONE;
            asc_out <= log_sense_pkg::ASC_NONE;
        end else if (state == S_CHECK) begin
            gen_idx <= 16'h0000;
            gen_limit <= limit;
            if (bad_opcode || bad_field) begin
                status_byte <= log_sense_pkg::STATUS_CHECK;
                sense_key_out <= log_sense_pkg::SENSE_ILLEGAL_REQUEST;
                asc_out <= bad_opcode ? log_sense_pkg::ASC_INVALID_OPCODE : log_sense_pkg::ASC_INVALID_FIELD_CDB;
            end else begin
                status_byte <= log_sense_pkg::STATUS_GOOD;
                sense_key_out <= log_sense_pkg::SENSE_NONE;
                asc_out <= log_sense_pkg::ASC_NONE;
            end
        end else if (fifo_in_valid && fifo_in_ready) begin
            gen_idx <= gen_idx + 16'h0001;
        end
    end
endmodule : log_sense_target

// *** verilog/log_sense_initiator.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Initiator end: one log request and its answer
// ----------------------------------------------------------------
module log_sense_initiator (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link to target
    scsi_link_if.initiator link,
    // Request
    input wire logic start_in,
    input wire logic [5:0] page_code_in,
    input wire logic [15:0] pointer_in,
    input wire logic [15:0] alloc_len_in,
    // Answer
    output logic busy_out,
    output logic [7:0] data_out,
    output logic data_valid_out,
    output logic [7:0] status_out,
    output logic done_out
);
    typedef enum logic [2:0] {
        I_IDLE = 3'b001,
        I_SEND = 3'b010,
        I_RECV = 3'b100
    } istate_type;

    istate_type state;
    logic [3:0] idx;
    logic [5:0] page;
    logic [15:0] pointer, alloc_len;

    function automatic logic [7:0] cdb_byte(input logic [3:0] i, input logic [5:0] pg,
                                            input logic [15:0] ptr, input logic [15:0] len);
        logic [7:0] b;
        case (i)
            4'h0: b = log_sense_pkg::OPCODE_LOG_SENSE;
            4'h1: b = 8'h00;
            4'h2: b = {log_sense_pkg::PAGE_CTRL_CUMULATIVE, pg};
            4'h5: b = ptr[15:8];
            4'h6: b = ptr[7:0];
            4'h7: b = len[15:8];
            4'h8: b = len[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction : cdb_byte

    wire last_cdb = idx == log_sense_pkg::CDB_LEN - 4'h1;
    wire rx = link.tgt_valid && (state == I_RECV);

    assign link.cdb_valid = (state == I_SEND);
    assign link.cdb_data = cdb_byte(idx, page, pointer, alloc_len);
    assign link.ini_ready = (state == I_RECV);
    assign busy_out = (state != I_IDLE);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= I_IDLE;
            idx <= 4'h0;
            page <= 6'h00;
            pointer <= 16'h0000;
            alloc_len <= 16'h0000;
            data_out <= 8'h00;
            data_valid_out <= 1'b0;
            status_out <= 8'h00;
            done_out <= 1'b0;
        end else begin
            data_valid_out <= 1'b0;
            done_out <= 1'b0;
            case (state)
                I_IDLE: begin
                    if (start_in && !link.bus_busy) begin
                        page <= page_code_in;
                        // Page list takes no pointer
                        pointer <= (page_code_in == log_sense_pkg::PAGE_SUPPORTED) ? 16'h0000 : pointer_in;
                        alloc_len <= alloc_len_in;
                        idx <= 4'h0;
                        state <= I_SEND;
                    end
                end
                I_SEND: begin
                    if (link.cdb_ready) begin
                        idx <= idx + 4'h1;
                        if (last_cdb) begin
                            state <= I_RECV;
                        end
                    end
                end
                I_RECV: begin
                    if (rx && (link.tgt_phase == log_sense_pkg::PHASE_DATA_IN)) begin
                        data_out <= link.tgt_data;
                        data_valid_out <= 1'b1;
                    end
                    if (rx && (link.tgt_phase == log_sense_pkg::PHASE_STATUS)) begin
                        status_out <= link.tgt_data;
                    end
                    if (rx && (link.tgt_phase == log_sense_pkg::PHASE_MSG_IN)) begin
                        done_out <= 1'b1;
                        state <= I_IDLE;
                    end
                end
                default: state <= I_IDLE;
            endcase
        end
    end
endmodule : log_sense_initiator

// *** tb/log_sense_properties.sv ***
`timescale 1ns/1ps
module log_sense_properties (
    // Clock and reset
    input logic clk_in,
    input logic rst_in,
    // Link signals
    input logic cdb_valid,
    input logic [7:0] cdb_data,
    input logic cdb_ready,
    input logic tgt_valid,
    input logic [7:0] tgt_data,
    input logic [1:0] tgt_phase,
    input logic ini_ready,
    input logic bus_busy
);
    // --------
    // Descriptor tracking
    // --------
    logic bad, seen;
    logic [3:0] idx;
    logic [5:0] page;
    logic [7:0] hi;
    logic [15:0] alloc, cnt;
    wire take = cdb_valid && cdb_ready;
    wire din = tgt_valid && tgt_phase == 2'h0;
    wire stat = tgt_valid && tgt_phase == 2'h1;
    wire msg_take = tgt_valid && ini_ready && tgt_phase == 2'h2;
    wire [15:0] ptr = {hi, cdb_data};
    // Verdict built byte by byte
    always_ff @(posedge clk_in) begin
        if (rst_in || msg_take) begin
            idx <= 4'h0;
            bad <= 1'b0;
        end else if (take) begin
            idx <= idx + 4'h1;
            case (idx)
                4'h0: bad <= cdb_data != 8'h4D;
                4'h1: bad <= bad || cdb_data[4:0] != 5'h00;
                4'h2: bad <= bad || cdb_data[7:6] != 2'h1 || !(cdb_data[5:0] inside {6'h00, 6'h30, 6'h31, 6'h32});
                4'h3, 4'h4: bad <= bad || cdb_data != 8'h00;
                4'h6: bad <= bad || (!ptr[15] && ptr > (page == 6'h00 ? 16'h0000 : 16'h0003));
                default: bad <= bad;
            endcase
        end
    end
    always_ff @(posedge clk_in) begin
        if (take && (idx == 4'h5 || idx == 4'h7)) hi <= cdb_data;
        if (take && idx == 4'h2) page <= cdb_data[5:0];
        if (take && idx == 4'h8) alloc <= ptr;
    end
    always_ff @(posedge clk_in) begin
        if (rst_in || msg_take) begin
            seen <= 1'b0;
            cnt <= 16'h0000;
        end else if (tgt_valid && ini_ready) begin
            seen <= seen || stat;
            cnt <= cnt + {15'h0000, din};
        end
    end
    // --------
    // Properties
    // --------
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    byte_holds_a: assert property (tgt_valid && !ini_ready |=> tgt_valid && $stable(tgt_data) && $stable(tgt_phase))
        else $error("byte changed while stalled");
    cdb_refused_a: assert property (tgt_valid |-> !cdb_ready)
        else $error("cdb taken while answering");
    status_value_a: assert property (stat |-> tgt_data == (bad ? 8'h02 : 8'h00))
        else $error("wrong status byte");
    error_no_data_a: assert property (bad |-> !din)
        else $error("data for rejected command");
    alloc_cap_a: assert property (din |-> cnt < alloc)
        else $error("data past allocation");
    data_first_a: assert property (din |-> !seen)
        else $error("data after status");
    header_page_a: assert property (din && cnt == 16'h0000 |-> tgt_data == {2'h0, page})
        else $error("wrong page code in header");
    message_next_a: assert property (stat && ini_ready |-> ##[1:8] (tgt_valid && tgt_phase == 2'h2 && tgt_data == 8'h00))
        else $error("no message after status");
    bus_free_a: assert property (msg_take |=> !bus_busy && cdb_ready)
        else $error("bus not free");
    answer_bound_a: assert property (take && idx == 4'h9 |-> ##[1:8] tgt_valid)
        else $error("no answer");
endmodule : log_sense_properties

// *** tb/test_log_sense_cdb_decoder.sv ***
`timescale 1ns/1ps
module test_log_sense_cdb_decoder;
    // --------
    // Clock, reset, links
    // --------
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    logic [5:0] page_code_in = 6'h00;
    logic [15:0] pointer_in = 16'h0000, alloc_len_in = 16'h0000;
    logic [log_sense_pkg::LOG_VALUES_BITS-1:0] vals;
    logic [7:0] data_out, status_out, stat;
    logic data_valid_out, done_out, busy;
    logic [3:0] key_a, key_b;
    logic [7:0] asc_a, asc_b;
    int bad_count = 0, checks = 0;
    logic [7:0] got[$];
    // Page, pointer, allocation, error
    logic [43:0] req_t [11] = '{44'h30_0000_0005_0, 44'h00_0000_FFFF_0, 44'h30_0000_FFFF_0, 44'h31_0002_0064_0,
        44'h32_0003_0007_0, 44'h32_0004_FFFF_1, 44'h30_8000_FFFF_0, 44'h33_0000_FFFF_1, 44'h01_0000_FFFF_1,
        44'h31_0000_0000_0, 44'h00_0000_0003_0};
    // Raw: one good with stall, then a bad opcode, then one bad field each
    logic [79:0] raw_t [9] = '{80'h4D007000000000FFFF00, 80'h4E007000000000001000, 80'h4D017000000000001000,
        80'h4D027000000000001000, 80'h4D003000000000001000, 80'h4D00F000000000001000,
        80'h4D007001000000001000, 80'h4D107000000000001000, 80'h4D004000000001001000};
    always #4 clk_in = ~clk_in;
    scsi_link_if link_a();
    scsi_link_if link_b();
    log_sense_initiator log_sense_initiator_inst (.clk_in(clk_in), .rst_in(rst_in), .link(link_a.initiator),
        .start_in(start_in), .page_code_in(page_code_in), .pointer_in(pointer_in), .alloc_len_in(alloc_len_in),
        .busy_out(busy), .data_out(data_out), .data_valid_out(data_valid_out), .status_out(status_out),
        .done_out(done_out));
    log_sense_target log_sense_target_inst (.clk_in(clk_in), .rst_in(rst_in), .link(link_a.target),
        .log_values_in(vals), .sense_key_out(key_a), .asc_out(asc_a), .busy_out());
    log_sense_target log_sense_target_inst_raw (.clk_in(clk_in), .rst_in(rst_in), .link(link_b.target),
        .log_values_in(vals), .sense_key_out(key_b), .asc_out(asc_b), .busy_out());
    log_sense_properties log_sense_properties_inst (.clk_in(clk_in), .rst_in(rst_in),
        .cdb_valid(link_b.cdb_valid), .cdb_data(link_b.cdb_data), .cdb_ready(link_b.cdb_ready),
        .tgt_valid(link_b.tgt_valid), .tgt_data(link_b.tgt_data), .tgt_phase(link_b.tgt_phase),
        .ini_ready(link_b.ini_ready), .bus_busy(link_b.bus_busy));
    // --------
    // Helpers
    // --------
    task automatic check(input string name, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    function automatic int exp_total(input logic [5:0] pg, input logic [15:0] ptr);
        return (pg == 6'h00) ? 8 : 4 + (4 - (ptr[15] ? 0 : int'(ptr))) * 6;
    endfunction : exp_total
    function automatic logic [7:0] exp_byte(input logic [5:0] pg, input logic [15:0] ptr, input int i);
        int st, j;
        logic [15:0] v, len;
        st = ptr[15] ? 0 : int'(ptr);
        j = i - 4;
        len = 16'((4 - st) * 6);
        v = 16'hA000 + 16'((pg - 6'h30) * 16 + st + j / 6);
        if (pg == 6'h00) begin
            return (i == 3) ? 8'h04 : ((i < 5) ? 8'h00 : 8'(8'h2B + i));
        end
        case (i)
            0: return {2'h0, pg};
            2: return len[15:8];
            3: return len[7:0];
            default: ;
        endcase
        case (j % 6)
            1: return 8'(st + j / 6);
            3: return 8'h02;
            4: return v[15:8];
            5: return v[7:0];
            default: return 8'h00;
        endcase
    endfunction : exp_byte
    task automatic compare(input logic [5:0] pg, input logic [15:0] ptr, al, input logic err,
                           input logic [3:0] key, input logic [7:0] asc, exp_asc);
        int n;
        n = err ? 0 : ((int'(al) < exp_total(pg, ptr)) ? int'(al) : exp_total(pg, ptr));
        check("data count", 16'(got.size()), 16'(n));
        for (int i = 0; i < got.size() && i < n; i++) begin
            check("data byte", {8'h00, got[i]}, {8'h00, exp_byte(pg, ptr, i)});
        end
        check("status", {8'h00, stat}, err ? 16'h0002 : 16'h0000);
        check("sense", {4'h0, key, asc}, err ? {8'h05, exp_asc} : 16'h0000);
    endtask : compare
    task automatic run_req(input logic [5:0] pg, input logic [15:0] ptr, al, input logic err);
        int n;
        got.delete();
        start_in = 1'b1;
        page_code_in = pg;
        pointer_in = ptr;
        alloc_len_in = al;
        @(posedge clk_in);
        #1;
        start_in = 1'b0;
        check("busy", {15'h0000, busy}, 16'h0001);
        for (n = 0; n < 2000 && done_out !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
            if (data_valid_out === 1'b1) got.push_back(data_out);
        end
        if (n == 2000) begin
            check("timeout", 16'h0000, 16'h0001);
            final_report();
        end
        stat = status_out;
        compare(pg, ptr, al, err, key_a, asc_a, 8'h24);
    endtask : run_req
    task automatic run_raw(input logic [79:0] cdb, input logic stall, input logic err, input logic [7:0] exp_asc);
        int n;
        got.delete();
        stat = 8'hFF;
        link_b.cdb_valid = 1'b1;
        for (int i = 0; i < 10; i++) begin
            link_b.cdb_data = cdb[79 - 8 * i -: 8];
            for (n = 0; n < 50; n++) begin
                @(posedge clk_in);
                if (link_b.cdb_ready === 1'b1) break;
            end
            #1;
        end
        link_b.cdb_valid = 1'b0;
        link_b.cdb_data = ~link_b.cdb_data;
        link_b.ini_ready = !stall;
        // A long stall fills the buffer
        for (n = 0; n < 2000; n++) begin
            @(posedge clk_in);
            if (link_b.tgt_valid === 1'b1 && link_b.ini_ready) begin
                if (link_b.tgt_phase == 2'h0) got.push_back(link_b.tgt_data);
                if (link_b.tgt_phase == 2'h1) stat = link_b.tgt_data;
                if (link_b.tgt_phase == 2'h2) break;
            end
            #1;
            link_b.ini_ready = !stall || n > 60;
        end
        if (n == 2000) begin
            check("timeout", 16'h0000, 16'h0001);
            final_report();
        end
        check("message", {8'h00, link_b.tgt_data}, 16'h0000);
        #1;
        link_b.ini_ready = 1'b0;
        @(posedge clk_in);
        #1;
        check("bus free", {15'h0000, link_b.bus_busy}, 16'h0000);
        compare(cdb[61:56], cdb[39:24], cdb[23:8], err, key_b, asc_b, exp_asc);
    endtask : run_raw
    // --------
    // Sequence
    // --------
    initial begin
        link_b.cdb_valid = 1'b0;
        link_b.cdb_data = 8'h00;
        link_b.ini_ready = 1'b0;
        for (int k = 0; k < 12; k++) begin
            vals[k * 16 +: 16] = 16'hA000 + 16'((k / 4) * 16 + k % 4);
        end
        repeat (4) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        foreach (req_t[i]) begin
            run_req(req_t[i][41:36], req_t[i][35:20], req_t[i][19:4], req_t[i][0]);
        end
        foreach (raw_t[i]) begin
            run_raw(raw_t[i], i == 0, i != 0, (i == 1) ? 8'h20 : 8'h24);
        end
        final_report();
    end
endmodule : test_log_sense_cdb_decoder
